// ---- core/diag_status_pkg.sv ----
// register map, field positions and reset values of the diagnostic status bank
// assumes an 16-bit register address and 8-bit register data
package diag_status_pkg;
    localparam logic [15:0] DIAG_COMPARE_READY_ADDR  = 16'h0528;
    localparam logic [15:0] GPIO_PIN_LEVELS_ADDR     = 16'h052a;
    localparam logic [15:0] CONVERTER_RUN_STATE_ADDR = 16'h052c;
    localparam logic [7:0]  STATUS_RESET             = 8'h00;
    localparam int FILTER_READY_BIT    = 5;
    localparam int PIN_XCHECK_BIT      = 4;
    localparam int SENSE_OW_BIT        = 3;
    localparam int AUX_OW_BIT          = 2;
    localparam int SENSE_VS_AUX_BIT    = 0;
    localparam int CS_RUN_BIT          = 2;
    localparam int AUX_RUN_BIT         = 1;
    localparam int MAIN_RUN_BIT        = 0;
    localparam int NUM_SENSE_CHANNELS  = 8;
    localparam logic [3:0] FILTER_CHANNEL_COUNT = 4'h9;
    typedef enum logic [1:0] {SYNC_GPIO, SYNC_RUN, SYNC_EVT} unused_t;
endpackage

// ---- core/flag_cell.sv ----
// one sticky completion flag: set by a finish pulse, cleared by a start pulse
// assumes both pulses come from logic on clk
`timescale 1ns/1ps
`default_nettype none
module flag_cell (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic set_pulse,
    input  wire logic clr_pulse,
    output logic      flag_q
);
    logic flag_d;
    // a finish in the same cycle as a start survives
    always_comb begin
        flag_d = flag_q;
        if (clr_pulse) begin
            flag_d = 1'b0;
        end
        if (set_pulse) begin
            flag_d = 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end
endmodule // flag_cell
`default_nettype wire

// ---- core/adc_diag_status_regs.sv ----
// diagnostic status register bank: completion flags, gpio levels, converter run state
// assumes converter status and finish pulses come from clk logic; gpio pins are async
// Function
// - filter ready sets after a full round of all 9 filter channels; compare start clears
// - filter comparisons keep cycling while the main converter runs
// - fault inject clears filter ready, restarts checks from first channel, sets when done
// - pin crosscheck ready sets when all gpio comparisons finish; compare start clears
// - sense open-wire ready sets when finished; compare start clears
// - aux open-wire ready sets when finished; compare start clears
// - sense versus aux ready sets when finished; compare start clears
// - gpio level register reports each digital pin, one is high
// - run bits show main, aux and current-sense converters on or off
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module adc_diag_status_regs
    import diag_status_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [7:0]  rdata,
    input  wire logic        compare_start,
    input  wire logic        filter_fault_inject,
    input  wire logic        filter_channel_done,
    input  wire logic        pin_crosscheck_done,
    input  wire logic        sense_openwire_done,
    input  wire logic        aux_openwire_done,
    input  wire logic        sense_vs_aux_done,
    input  wire logic [7:0]  gpio_pin,
    input  wire logic [7:0]  gpio_digital_mode,
    input  wire logic        main_running,
    input  wire logic        aux_running,
    input  wire logic        cs_running,
    output logic      [3:0]  filter_channel_q,
    output logic             filter_inject_active_q
);
    logic [7:0] gpio_meta_q, gpio_sync_q, gpio_lvl_q, gpio_lvl_d;
    logic [7:0] run_q, run_d;
    logic [7:0] rdata_d;
    logic [3:0] filter_channel_d;
    logic       filter_inject_active_d;
    logic       filter_round_done;
    logic       filter_ready_q, pin_ready_q, sense_ow_q, aux_ow_q, vs_aux_q;
    logic       filter_clear;
    logic       any_event;
    logic [7:0] flags_vec;

    // the filter engine walks channels and wraps while the main converter runs
    always_comb begin
        filter_channel_d       = filter_channel_q;
        filter_inject_active_d = filter_inject_active_q;
        filter_round_done      = 1'b0;
        if (filter_fault_inject) begin
            filter_channel_d       = 4'h0;
            filter_inject_active_d = 1'b1;
        end else if (main_running && filter_channel_done) begin
            if (filter_channel_q == FILTER_CHANNEL_COUNT - 4'h1) begin
                filter_channel_d       = 4'h0;
                filter_round_done      = 1'b1;
                filter_inject_active_d = 1'b0;
            end else begin
                filter_channel_d = filter_channel_q + 4'h1;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            filter_channel_q       <= 4'h0;
            filter_inject_active_q <= 1'b0;
        end else begin
            filter_channel_q       <= filter_channel_d;
            filter_inject_active_q <= filter_inject_active_d;
        end
    end

    // fault inject also clears the filter flag
    assign filter_clear = compare_start || filter_fault_inject;

    flag_cell u_filter (
        .clk       (clk),
        .nrst      (nrst),
        .set_pulse (filter_round_done),
        .clr_pulse (filter_clear),
        .flag_q    (filter_ready_q)
    );

    flag_cell u_pin (
        .clk       (clk),
        .nrst      (nrst),
        .set_pulse (pin_crosscheck_done),
        .clr_pulse (compare_start),
        .flag_q    (pin_ready_q)
    );

    flag_cell u_sow (
        .clk       (clk),
        .nrst      (nrst),
        .set_pulse (sense_openwire_done),
        .clr_pulse (compare_start),
        .flag_q    (sense_ow_q)
    );

    flag_cell u_aow (
        .clk       (clk),
        .nrst      (nrst),
        .set_pulse (aux_openwire_done),
        .clr_pulse (compare_start),
        .flag_q    (aux_ow_q)
    );

    flag_cell u_vsa (
        .clk       (clk),
        .nrst      (nrst),
        .set_pulse (sense_vs_aux_done),
        .clr_pulse (compare_start),
        .flag_q    (vs_aux_q)
    );

    // pins are asynchronous: two flops before use
    always_comb begin
        gpio_lvl_d = gpio_sync_q & gpio_digital_mode;
        run_d      = STATUS_RESET;
        run_d[MAIN_RUN_BIT] = main_running;
        run_d[AUX_RUN_BIT]  = aux_running;
        run_d[CS_RUN_BIT]   = cs_running;
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            gpio_meta_q <= STATUS_RESET;
            gpio_sync_q <= STATUS_RESET;
            gpio_lvl_q  <= STATUS_RESET;
            run_q       <= STATUS_RESET;
        end else begin
            gpio_meta_q <= gpio_pin;
            gpio_sync_q <= gpio_meta_q;
            gpio_lvl_q  <= gpio_lvl_d;
            run_q       <= run_d;
        end
    end

    // read mux; writes are ignored since every register here is read-only
    always_comb begin
        rdata_d = STATUS_RESET;
        if (rd_en) begin
            case (addr)
                DIAG_COMPARE_READY_ADDR: begin
                    rdata_d[FILTER_READY_BIT] = filter_ready_q;
                    rdata_d[PIN_XCHECK_BIT]   = pin_ready_q;
                    rdata_d[SENSE_OW_BIT]     = sense_ow_q;
                    rdata_d[AUX_OW_BIT]       = aux_ow_q;
                    rdata_d[SENSE_VS_AUX_BIT] = vs_aux_q;
                end
                GPIO_PIN_LEVELS_ADDR:     rdata_d = gpio_lvl_q;
                CONVERTER_RUN_STATE_ADDR: rdata_d = run_q;
                default:                  rdata_d = STATUS_RESET;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata <= STATUS_RESET;
        end else begin
            rdata <= rdata_d;
        end
    end

    // packed flag view and a quiet-cycle marker, used by the write check below
    always_comb begin
        flags_vec                   = STATUS_RESET;
        flags_vec[FILTER_READY_BIT] = filter_ready_q;
        flags_vec[PIN_XCHECK_BIT]   = pin_ready_q;
        flags_vec[SENSE_OW_BIT]     = sense_ow_q;
        flags_vec[AUX_OW_BIT]       = aux_ow_q;
        flags_vec[SENSE_VS_AUX_BIT] = vs_aux_q;
        any_event = compare_start || filter_fault_inject || filter_round_done
                    || pin_crosscheck_done || sense_openwire_done
                    || aux_openwire_done || sense_vs_aux_done;
    end

    // true only for the three status addresses
    function automatic logic reg_mapped(input logic [15:0] a);
        return (a == DIAG_COMPARE_READY_ADDR) || (a == GPIO_PIN_LEVELS_ADDR)
            || (a == CONVERTER_RUN_STATE_ADDR);
    endfunction

    // flag checks: a start clears, a finish sets, nothing else raises a flag
    a_filter_clear: assert property (
        @(posedge clk) disable iff (!nrst)
        (compare_start && !filter_round_done) |=> !filter_ready_q)
        else $error("filter ready not cleared by compare start");
    a_filter_set: assert property (
        @(posedge clk) disable iff (!nrst)
        filter_round_done |=> filter_ready_q)
        else $error("filter ready not set after round");
    a_filter_rise: assert property (
        @(posedge clk) disable iff (!nrst)
        !filter_round_done |=> !$rose(filter_ready_q))
        else $error("filter ready rose without a finished round");
    a_pin_flag: assert property (
        @(posedge clk) disable iff (!nrst)
        pin_crosscheck_done |=> pin_ready_q)
        else $error("pin crosscheck flag not set");
    a_pin_clear: assert property (
        @(posedge clk) disable iff (!nrst)
        (compare_start && !pin_crosscheck_done) |=> !pin_ready_q)
        else $error("pin crosscheck flag not cleared");
    a_pin_rise: assert property (
        @(posedge clk) disable iff (!nrst)
        !pin_crosscheck_done |=> !$rose(pin_ready_q))
        else $error("pin crosscheck flag rose without a finish");
    a_sow_flag: assert property (
        @(posedge clk) disable iff (!nrst)
        (compare_start && !sense_openwire_done) |=> !sense_ow_q)
        else $error("sense open-wire flag not cleared");
    a_sow_set: assert property (
        @(posedge clk) disable iff (!nrst)
        sense_openwire_done |=> sense_ow_q)
        else $error("sense open-wire flag not set");
    a_sow_rise: assert property (
        @(posedge clk) disable iff (!nrst)
        !sense_openwire_done |=> !$rose(sense_ow_q))
        else $error("sense open-wire flag rose without a finish");
    a_aow_flag: assert property (
        @(posedge clk) disable iff (!nrst)
        aux_openwire_done |=> aux_ow_q)
        else $error("aux open-wire flag not set");
    a_aow_clear: assert property (
        @(posedge clk) disable iff (!nrst)
        (compare_start && !aux_openwire_done) |=> !aux_ow_q)
        else $error("aux open-wire flag not cleared");
    a_aow_rise: assert property (
        @(posedge clk) disable iff (!nrst)
        !aux_openwire_done |=> !$rose(aux_ow_q))
        else $error("aux open-wire flag rose without a finish");
    a_vsaux_flag: assert property (
        @(posedge clk) disable iff (!nrst)
        sense_vs_aux_done |=> vs_aux_q)
        else $error("sense vs aux flag not set");
    a_vsaux_clear: assert property (
        @(posedge clk) disable iff (!nrst)
        (compare_start && !sense_vs_aux_done) |=> !vs_aux_q)
        else $error("sense vs aux flag not cleared");
    a_vsaux_rise: assert property (
        @(posedge clk) disable iff (!nrst)
        !sense_vs_aux_done |=> !$rose(vs_aux_q))
        else $error("sense vs aux flag rose without a finish");

    // filter engine: one step per finish, only while the main converter runs
    a_filter_wrap: assert property (
        @(posedge clk) disable iff (!nrst)
        (!filter_fault_inject && main_running && filter_channel_done
         && filter_channel_q == FILTER_CHANNEL_COUNT - 4'h1) |=> filter_channel_q == 4'h0)
        else $error("filter engine did not wrap");
    a_channel_step: assert property (
        @(posedge clk) disable iff (!nrst)
        (!filter_fault_inject && main_running && filter_channel_done
         && filter_channel_q != FILTER_CHANNEL_COUNT - 4'h1)
        |=> filter_channel_q == $past(filter_channel_q) + 4'h1)
        else $error("filter engine did not step to the next channel");
    a_filter_hold: assert property (
        @(posedge clk) disable iff (!nrst)
        (!main_running && !filter_fault_inject) |=> $stable(filter_channel_q))
        else $error("filter engine moved with the main converter off");
    a_channel_range: assert property (
        @(posedge clk) disable iff (!nrst)
        filter_channel_q < FILTER_CHANNEL_COUNT)
        else $error("filter channel out of range");
    a_inject_restart: assert property (
        @(posedge clk) disable iff (!nrst)
        filter_fault_inject |=> (filter_channel_q == 4'h0 && filter_inject_active_q))
        else $error("fault inject did not restart filter checks");
    a_inject_clears: assert property (
        @(posedge clk) disable iff (!nrst)
        filter_fault_inject |=> !filter_ready_q)
        else $error("fault inject did not clear filter ready");
    a_round_ends_inject: assert property (
        @(posedge clk) disable iff (!nrst)
        filter_round_done |=> !filter_inject_active_q)
        else $error("injected round marker stayed after the round");
    a_inject_hold: assert property (
        @(posedge clk) disable iff (!nrst)
        (!filter_fault_inject && !filter_round_done) |=> $stable(filter_inject_active_q))
        else $error("injected round marker changed without cause");
    a_inject_no_flag: assert property (
        @(posedge clk) disable iff (!nrst)
        filter_inject_active_q |-> !filter_ready_q)
        else $error("filter ready high during an injected round");

    // read side: data stands for the one cycle after the strobe, zero otherwise
    a_gpio_read: assert property (
        @(posedge clk) disable iff (!nrst)
        (rd_en && addr == GPIO_PIN_LEVELS_ADDR) |=> rdata == $past(gpio_lvl_q))
        else $error("gpio level read mismatch");
    a_gpio_mode: assert property (
        @(posedge clk) disable iff (!nrst)
        (rd_en && addr == GPIO_PIN_LEVELS_ADDR)
        |=> (rdata & ~$past(gpio_digital_mode, 2)) == STATUS_RESET)
        else $error("gpio pin outside digital mode read as high");
    a_run_read: assert property (
        @(posedge clk) disable iff (!nrst)
        (rd_en && addr == CONVERTER_RUN_STATE_ADDR) |=> (rdata[7:3] == 5'h00
         && rdata[MAIN_RUN_BIT] == $past(main_running, 2)
         && rdata[AUX_RUN_BIT] == $past(aux_running, 2)
         && rdata[CS_RUN_BIT] == $past(cs_running, 2)))
        else $error("run state read mismatch");
    a_reserved_zero: assert property (
        @(posedge clk) disable iff (!nrst)
        (rd_en && addr == DIAG_COMPARE_READY_ADDR) |=> (rdata[7:6] == 2'h0 && !rdata[1]))
        else $error("reserved status bits nonzero");
    a_flags_read: assert property (
        @(posedge clk) disable iff (!nrst)
        (rd_en && addr == DIAG_COMPARE_READY_ADDR) |=> rdata == $past(flags_vec))
        else $error("completion flags read mismatch");
    a_unmapped_zero: assert property (
        @(posedge clk) disable iff (!nrst)
        (rd_en && !reg_mapped(addr)) |=> rdata == STATUS_RESET)
        else $error("unmapped read returned nonzero data");
    a_idle_zero: assert property (
        @(posedge clk) disable iff (!nrst)
        !rd_en |=> rdata == STATUS_RESET)
        else $error("read data did not return to zero");
    a_write_ignored: assert property (
        @(posedge clk) disable iff (!nrst)
        (wr_en && (|wdata) && !any_event) |=> $stable(flags_vec))
        else $error("register write changed a status flag");
endmodule // adc_diag_status_regs
`default_nettype wire

// ---- bench/adc_diag_status_regs_tb_top.sv ----
// self-checking bench for the diagnostic status register bank
// assumes registered read data one cycle after rd_en and finish pulses on clk
`timescale 1ns/1ps
`default_nettype none
module adc_diag_status_regs_tb_top
    import diag_status_pkg::*;
;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [7:0]  rdata;
    logic [6:0]  evt = 7'h00;
    logic [7:0]  gpio_pin = 8'h00;
    logic [7:0]  gpio_mode = 8'h00;
    logic [2:0]  run = 3'h0;
    logic [3:0]  chan;
    logic        inj_act;
    logic [7:0]  acc;
    int          err_count = 0;
    int          cmp_count = 0;
    // pin, mode, run inputs, expected pin levels, expected run state
    logic [39:0] rows [5] = '{40'ha5ff01a501, 40'ha50f020502, 40'hff00040004,
                              40'h3cf0073007, 40'h00ff000000};
    logic [7:0]  fbit [4] = '{8'h10, 8'h08, 8'h04, 8'h01};

    always #5 clk = ~clk;

    adc_diag_status_regs u_adc_diag_status_regs (
        .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .compare_start(evt[0]),
        .filter_fault_inject(evt[1]), .filter_channel_done(evt[2]),
        .pin_crosscheck_done(evt[3]), .sense_openwire_done(evt[4]),
        .aux_openwire_done(evt[5]), .sense_vs_aux_done(evt[6]),
        .gpio_pin(gpio_pin), .gpio_digital_mode(gpio_mode), .main_running(run[0]),
        .aux_running(run[1]), .cs_running(run[2]), .filter_channel_q(chan),
        .filter_inject_active_q(inj_act));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk("rdata", exp, rdata);
    endtask
    // channel position and injected-round marker, sampled once the edge has landed
    task automatic chq(input logic [3:0] exp, input logic exp_inj);
        #1;
        chk("channel", {4'h0, exp}, {4'h0, chan});
        chk("inject", {7'h00, exp_inj}, {7'h00, inj_act});
    endtask
    task automatic pulse(input logic [6:0] m);
        @(posedge clk);
        evt <= m;
        @(posedge clk);
        evt <= 7'h00;
    endtask
    task automatic filt(input int n);
        repeat (n) pulse(7'h04);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // cuts a hang short well inside the cycle budget
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        stop_test();
    end

    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rd(DIAG_COMPARE_READY_ADDR, STATUS_RESET);
        rd(CONVERTER_RUN_STATE_ADDR, STATUS_RESET);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            gpio_pin  <= rows[i][39:32];
            gpio_mode <= rows[i][31:24];
            run       <= rows[i][18:16];
            repeat (4) @(posedge clk);
            rd(GPIO_PIN_LEVELS_ADDR, rows[i][15:8]);
            rd(CONVERTER_RUN_STATE_ADDR, rows[i][7:0]);
        end
        $display("test table done");
        @(posedge clk);
        wr_en <= 1'b1;
        addr  <= DIAG_COMPARE_READY_ADDR;
        wdata <= 8'hff;
        @(posedge clk);
        wr_en <= 1'b0;
        rd(DIAG_COMPARE_READY_ADDR, 8'h00);
        rd(16'h0529, 8'h00);
        $display("test read only done");
        acc = 8'h00;
        for (int i = 0; i < 4; i++) begin
            pulse(7'h08 << i);
            acc = acc | fbit[i];
            rd(DIAG_COMPARE_READY_ADDR, acc);
        end
        // read data stands for one cycle only, then falls back to zero
        @(posedge clk);
        #1;
        chk("rdata idle", STATUS_RESET, rdata);
        pulse(7'h01);
        rd(DIAG_COMPARE_READY_ADDR, 8'h00);
        // finish in the same cycle as a new start must not be lost
        pulse(7'h09);
        rd(DIAG_COMPARE_READY_ADDR, 8'h10);
        pulse(7'h01);
        $display("test flags done");
        @(posedge clk);
        run <= 3'h1;
        filt(int'(FILTER_CHANNEL_COUNT) - 1);
        chq(FILTER_CHANNEL_COUNT - 4'h1, 1'b0);
        rd(DIAG_COMPARE_READY_ADDR, 8'h00);
        filt(1);
        chq(4'h0, 1'b0);
        rd(DIAG_COMPARE_READY_ADDR, 8'h20);
        filt(2);
        chq(4'h2, 1'b0);
        pulse(7'h02);
        chq(4'h0, 1'b1);
        rd(DIAG_COMPARE_READY_ADDR, 8'h00);
        filt(int'(FILTER_CHANNEL_COUNT) - 1);
        rd(DIAG_COMPARE_READY_ADDR, 8'h00);
        filt(1);
        rd(DIAG_COMPARE_READY_ADDR, 8'h20);
        @(posedge clk);
        run <= 3'h0;
        filt(3);
        chq(4'h0, 1'b0);
        pulse(7'h01);
        rd(DIAG_COMPARE_READY_ADDR, 8'h00);
        $display("test filter done");
        pulse(7'h08);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd(DIAG_COMPARE_READY_ADDR, STATUS_RESET);
        $display("test reset done");
        stop_test();
    end
endmodule // adc_diag_status_regs_tb_top
`default_nettype wire
